// ==== design/tef_defs.svh ====
// Offsets, field positions and reset values of the timing event flag block
`ifndef TEF_DEFS_SVH
`define TEF_DEFS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define TEF_OFS_FREQ_READBACK 8'h07
`define TEF_OFS_EVENT_FLAGS 8'h08

// ****************************************************************
// Reset values
// ****************************************************************
`define TEF_RST_FREQ_READBACK 8'h00
`define TEF_RST_EVENT_FLAGS 8'h50
`define TEF_RST_RDATA 8'h00

// ****************************************************************
// Field positions
// ****************************************************************
`define TEF_FREQ_TOP_BIT 18
`define TEF_FREQ_LOW_BIT 16
`define TEF_FREQ_MIN_W 19
`define TEF_BIT_FRAME_SYNC 7
`define TEF_BIT_LOCK_CHANGE 6
`define TEF_BIT_PHASE_ALARM 5
`define TEF_BIT_NO_INPUTS 4
`define TEF_BIT_IN2_VIOL 3
`define TEF_BIT_IN2_LOS 2
`define TEF_BIT_IN1_VIOL 1
`define TEF_BIT_IN1_LOS 0

`endif

// ==== design/tef_pkg.sv ====
// Types shared by the timing event flag block
package tef_pkg;

   // ****************************************************************
   // Host register access request
   // ****************************************************************
   typedef struct packed {
      logic rd;
      logic wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } tef_req_t;

   // ****************************************************************
   // Raw event sources
   // ****************************************************************
   typedef struct packed {
      logic frame_sync_alarm;
      logic second_pll_locked;
      logic second_pll_no_inputs;
      logic in2_code_viol;
      logic in2_sig_loss;
      logic in1_code_viol;
      logic in1_sig_loss;
   } tef_evt_t;

endpackage

// ==== design/tef_w1c_flags.sv ====
// Sticky flag bank, set by hardware and cleared by writing one
`timescale 1ns/1ps
module tef_w1c_flags #(
   parameter int W = 8,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   input wire logic [W-1:0] set,
   input wire logic [W-1:0] clr,
   output logic [W-1:0] flags
);

   if (W < 1) begin : g_bad_w
      $error("W must be at least one");
   end

   logic [W-1:0] flags_q;
   logic [W-1:0] flags_d;

   // ****************************************************************
   // Set has priority over a coincident clear; zero bits keep state
   // ****************************************************************
   always_comb begin
      flags_d = (flags_q & ~clr) | set;
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         flags_q <= RST_VAL;
      end else if (ce) begin
         flags_q <= flags_d;
      end
   end

   assign flags = flags_q;

endmodule

// ==== design/tef_event_flags_high.sv ====
// Frequency readback and upper event flag registers of the timing source
`timescale 1ns/1ps
`include "tef_defs.svh"

// Summary of operation
// - Register 0x07 shows selected path frequency bits 18:16; bits 7:3 zero.
// - Flag 7 sets on frame-sync alarm and stays until cleared.
// - Flag 6 sets on any lock change of second PLL, sticky.
// - Flag 5 sets when measured phase exceeds threshold, sticky.
// - Flag 4 sets when second PLL has no valid inputs, sticky.
// - Code violation latches in flag 1 for input one, 3 for two.
// - Signal loss latches in flag 0 for input one, 2 for two.
// - Host writes one to a flag bit to clear it.
module tef_event_flags_high
   import tef_pkg::*;
#(
   parameter int FREQ_W = 19,
   parameter int PH_W = 16
) (
   input wire logic CLK_SYS,
   input wire logic NRST,
   input wire logic CE,
   input tef_req_t REG_REQ,
   output logic [7:0] REG_RDATA,
   output logic REG_RVALID,
   input wire logic READBACK_PATH_SELECT,
   input wire logic [FREQ_W-1:0] MAIN_PATH_FREQ,
   input wire logic [FREQ_W-1:0] SECOND_PATH_FREQ,
   input wire logic [PH_W-1:0] PHASE_MEAS,
   input wire logic [PH_W-1:0] PHASE_LIMIT,
   input tef_evt_t EVENTS
);

   // ****************************************************************
   // Elaboration checks
   // ****************************************************************
   if (FREQ_W < `TEF_FREQ_MIN_W) begin : g_bad_freq_w
      $error("FREQ_W too small for frequency readback");
   end
   if (PH_W < 1) begin : g_bad_ph_w
      $error("PH_W must be at least one");
   end

   // ****************************************************************
   // Declarations
   // ****************************************************************
   logic lock_prev_q;
   logic [7:0] set_v;
   logic [7:0] clr_v;
   logic [7:0] flags;
   logic [7:0] rdata_q;
   logic [7:0] rdata_d;
   logic rvalid_q;
   logic [2:0] freq_top;
   logic flag_wr;

   // ****************************************************************
   // Helper functions
   // ****************************************************************
   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction

   function automatic logic [2:0] top_bits(input logic [FREQ_W-1:0] f);
      top_bits = f[`TEF_FREQ_TOP_BIT:`TEF_FREQ_LOW_BIT];
   endfunction

   // ****************************************************************
   // Frequency readback path
   // ****************************************************************
   always_comb begin
      if (READBACK_PATH_SELECT) begin
         freq_top = top_bits(SECOND_PATH_FREQ);
      end else begin
         freq_top = top_bits(MAIN_PATH_FREQ);
      end
   end

   // ****************************************************************
   // Lock state history for change detection
   // ****************************************************************
   always_ff @(posedge CLK_SYS or negedge NRST) begin
      if (!NRST) begin
         lock_prev_q <= 1'b0;
      end else if (CE) begin
         lock_prev_q <= EVENTS.second_pll_locked;
      end
   end

   // ****************************************************************
   // Event set vector
   // ****************************************************************
   always_comb begin
      set_v = 8'h00;
      set_v[`TEF_BIT_FRAME_SYNC] = EVENTS.frame_sync_alarm;
      set_v[`TEF_BIT_LOCK_CHANGE] =
         EVENTS.second_pll_locked ^ lock_prev_q;
      set_v[`TEF_BIT_PHASE_ALARM] = (PHASE_MEAS > PHASE_LIMIT);
      set_v[`TEF_BIT_NO_INPUTS] = EVENTS.second_pll_no_inputs;
      set_v[`TEF_BIT_IN2_VIOL] = EVENTS.in2_code_viol;
      set_v[`TEF_BIT_IN1_VIOL] = EVENTS.in1_code_viol;
      set_v[`TEF_BIT_IN2_LOS] = EVENTS.in2_sig_loss;
      set_v[`TEF_BIT_IN1_LOS] = EVENTS.in1_sig_loss;
   end

   // ****************************************************************
   // Write decode: only the flag register accepts writes
   // ****************************************************************
   always_comb begin
      flag_wr = REG_REQ.wr && hit(REG_REQ.addr, `TEF_OFS_EVENT_FLAGS);
      clr_v = flag_wr ? REG_REQ.wdata : 8'h00;
   end

   tef_w1c_flags #(
      .W(8),
      .RST_VAL(`TEF_RST_EVENT_FLAGS)
   ) u_flags (
      .clk(CLK_SYS),
      .nrst(NRST),
      .ce(CE),
      .set(set_v),
      .clr(clr_v),
      .flags(flags)
   );

   // ****************************************************************
   // Read path, registered one cycle after the read request
   // ****************************************************************
   always_comb begin
      rdata_d = `TEF_RST_RDATA;
      if (hit(REG_REQ.addr, `TEF_OFS_FREQ_READBACK)) begin
         rdata_d = {5'h00, freq_top};
      end else if (hit(REG_REQ.addr, `TEF_OFS_EVENT_FLAGS)) begin
         rdata_d = flags;
      end
   end

   always_ff @(posedge CLK_SYS or negedge NRST) begin
      if (!NRST) begin
         rdata_q <= `TEF_RST_RDATA;
      end else if (CE && REG_REQ.rd) begin
         rdata_q <= rdata_d;
      end
   end

   always_ff @(posedge CLK_SYS or negedge NRST) begin
      if (!NRST) begin
         rvalid_q <= 1'b0;
      end else if (CE) begin
         rvalid_q <= REG_REQ.rd;
      end
   end

   assign REG_RDATA = rdata_q;
   assign REG_RVALID = rvalid_q;

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking cb @(posedge CLK_SYS);
   endclocking
   default disable iff (!NRST);

   chk_freq_zero_high: assert property (
      CE && REG_REQ.rd && hit(REG_REQ.addr, `TEF_OFS_FREQ_READBACK)
      |=> REG_RDATA[7:3] == 5'h00 && REG_RVALID)
      else $error("Frequency readback upper bits not zero");

   chk_freq_path_sel: assert property (
      CE && REG_REQ.rd && hit(REG_REQ.addr, `TEF_OFS_FREQ_READBACK)
      |=> REG_RDATA[2:0] == ($past(READBACK_PATH_SELECT) ?
         $past(SECOND_PATH_FREQ[18:16]) : $past(MAIN_PATH_FREQ[18:16])))
      else $error("Frequency readback shows wrong path");

   chk_sync_alarm_set: assert property (
      CE && EVENTS.frame_sync_alarm |=> flags[`TEF_BIT_FRAME_SYNC])
      else $error("Frame sync alarm flag not set");

   chk_lock_change_set: assert property (
      CE && (EVENTS.second_pll_locked != lock_prev_q)
      |=> flags[`TEF_BIT_LOCK_CHANGE])
      else $error("Lock change flag not set");

   chk_phase_alarm_set: assert property (
      CE && (PHASE_MEAS > PHASE_LIMIT) |=> flags[`TEF_BIT_PHASE_ALARM])
      else $error("Phase alarm flag not set");

   chk_no_inputs_set: assert property (
      CE && EVENTS.second_pll_no_inputs |=> flags[`TEF_BIT_NO_INPUTS])
      else $error("No inputs flag not set");

   chk_code_viol_set: assert property (
      CE ##0 (EVENTS.in1_code_viol || EVENTS.in2_code_viol)
      |=> (!$past(EVENTS.in1_code_viol) || flags[`TEF_BIT_IN1_VIOL]) &&
          (!$past(EVENTS.in2_code_viol) || flags[`TEF_BIT_IN2_VIOL]))
      else $error("Code violation flag not set");

   chk_sig_loss_set: assert property (
      CE ##0 (EVENTS.in1_sig_loss || EVENTS.in2_sig_loss)
      |=> (!$past(EVENTS.in1_sig_loss) || flags[`TEF_BIT_IN1_LOS]) &&
          (!$past(EVENTS.in2_sig_loss) || flags[`TEF_BIT_IN2_LOS]))
      else $error("Signal loss flag not set");

   chk_w1c_clears: assert property (
      CE && flag_wr
      |=> (flags & $past(REG_REQ.wdata) & ~$past(set_v)) == 8'h00)
      else $error("Written one did not clear flag");

   chk_flag_holds: assert property (
      CE |=> (($past(flags) & ~$past(clr_v)) & ~flags) == 8'h00)
      else $error("Flag dropped without clearing write");

   chk_ro_write_ignored: assert property (
      CE && REG_REQ.wr && hit(REG_REQ.addr, `TEF_OFS_FREQ_READBACK)
      |=> flags == ($past(flags) | $past(set_v)))
      else $error("Write to readback register altered flags");

   chk_ce_freezes: assert property (
      !CE |=> $stable(flags) && $stable(REG_RDATA) && $stable(REG_RVALID))
      else $error("State changed while clock enable low");

   cov_flag_clear: cover property (
      CE && flag_wr && (flags & REG_REQ.wdata) != 8'h00);
   cov_set_clear_clash: cover property (
      CE && flag_wr && (set_v & REG_REQ.wdata) != 8'h00);
   cov_lock_change: cover property (
      CE && (EVENTS.second_pll_locked != lock_prev_q));
   cov_second_path_read: cover property (
      CE && REG_REQ.rd && READBACK_PATH_SELECT &&
      hit(REG_REQ.addr, `TEF_OFS_FREQ_READBACK));

endmodule

// ==== dv/tef_event_flags_high_test.sv ====
// Self-checking testbench of the timing event flag block
`timescale 1ns/1ps
module tef_event_flags_high_test;
   import tef_pkg::*;

   // ****************************************************************
   // Stimulus and observed signals
   // ****************************************************************
   logic clk_sys = 1'b0;
   logic nrst = 1'b0;
   logic ce = 1'b1;
   tef_req_t req = '0;
   logic [7:0] rdata;
   logic rvalid;
   logic sel = 1'b0;
   logic [18:0] main_f = '0;
   logic [18:0] sec_f = '0;
   logic [15:0] ph_meas = 16'h0000;
   logic [15:0] ph_lim = 16'h0100;
   tef_evt_t evt = '0;
   int miscompares = 0;
   int tests_run = 0;
   logic [6:0] ev_tab [6] = '{7'h40, 7'h10, 7'h08, 7'h04, 7'h02, 7'h01};
   logic [7:0] fl_tab [6] = '{8'h80, 8'h10, 8'h08, 8'h04, 8'h02, 8'h01};

   always #25 clk_sys = ~clk_sys;

   tef_event_flags_high #(.FREQ_W(19), .PH_W(16)) u_dut (
      .CLK_SYS(clk_sys),
      .NRST(nrst),
      .CE(ce),
      .REG_REQ(req),
      .REG_RDATA(rdata),
      .REG_RVALID(rvalid),
      .READBACK_PATH_SELECT(sel),
      .MAIN_PATH_FREQ(main_f),
      .SECOND_PATH_FREQ(sec_f),
      .PHASE_MEAS(ph_meas),
      .PHASE_LIMIT(ph_lim),
      .EVENTS(evt)
   );

   // ****************************************************************
   // Shared tasks
   // ****************************************************************
   task automatic check(input string what, input logic [7:0] seen,
                        input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic step;
      @(posedge clk_sys);
      #1;
   endtask

   // Read with one idle cycle after, so strobes never toggle twice at once
   task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp,
                         input string what);
      req.rd = 1'b1;
      req.addr = addr;
      step();
      req.rd = 1'b0;
      check("rvalid", {7'h00, rvalid}, 8'h01);
      check(what, rdata, exp);
      step();
   endtask

   task automatic reg_write(input logic [7:0] addr, input logic [7:0] data);
      req.wr = 1'b1;
      req.addr = addr;
      req.wdata = data;
      step();
      req.wr = 1'b0;
      step();
   endtask

   task automatic conclude;
      $display("miscompares %0d tests_run %0d", miscompares, tests_run);
      if (miscompares == 0 && tests_run > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // ****************************************************************
   // Scenarios
   // ****************************************************************
   task automatic t_reset_clear;
      rd_chk(8'h08, 8'h50, "flags_reset");
      rd_chk(8'h07, 8'h00, "freq_reset");
      rd_chk(8'h3c, 8'h00, "unmapped");
      reg_write(8'h08, 8'h00);
      rd_chk(8'h08, 8'h50, "write_zero");
      reg_write(8'h08, 8'h10);
      rd_chk(8'h08, 8'h40, "clear_one");
      reg_write(8'h08, 8'h40);
      rd_chk(8'h08, 8'h00, "clear_other");
   endtask

   // One-cycle event pulse per source except second_pll_locked, then clear exactly that bit
   task automatic t_events;
      for (int i = 0; i < 6; i++) begin
         evt = tef_evt_t'(ev_tab[i]);
         step();
         evt = '0;
         rd_chk(8'h08, fl_tab[i], "event_set");
         reg_write(8'h08, fl_tab[i]);
         rd_chk(8'h08, 8'h00, "event_clear");
      end
   endtask

   task automatic t_lock;
      evt.second_pll_locked = 1'b1;
      step();
      rd_chk(8'h08, 8'h40, "lock_gain");
      reg_write(8'h08, 8'h40);
      rd_chk(8'h08, 8'h00, "lock_steady");
      evt.second_pll_locked = 1'b0;
      step();
      rd_chk(8'h08, 8'h40, "lock_loss");
      reg_write(8'h08, 8'h40);
   endtask

   task automatic t_phase;
      ph_meas = ph_lim;
      step();
      rd_chk(8'h08, 8'h00, "phase_equal");
      ph_meas = ph_lim + 16'h0001;
      step();
      ph_meas = 16'h0000;
      rd_chk(8'h08, 8'h20, "phase_over");
      reg_write(8'h08, 8'h20);
   endtask

   // Event and clearing write taken at the same edge
   task automatic t_coincide;
      evt.in1_sig_loss = 1'b1;
      req.wr = 1'b1;
      req.addr = 8'h08;
      req.wdata = 8'h01;
      step();
      evt.in1_sig_loss = 1'b0;
      req.wr = 1'b0;
      step();
      rd_chk(8'h08, 8'h01, "set_wins");
      reg_write(8'h08, 8'h01);
      rd_chk(8'h08, 8'h00, "after_clear");
   endtask

   // Clock enable low freezes flags and the read port
   task automatic t_ce;
      evt.frame_sync_alarm = 1'b1;
      step();
      evt.frame_sync_alarm = 1'b0;
      ce = 1'b0;
      evt.in1_sig_loss = 1'b1;
      req.wr = 1'b1;
      req.rd = 1'b1;
      req.addr = 8'h08;
      req.wdata = 8'hff;
      step();
      check("ce_rvalid", {7'h00, rvalid}, 8'h00);
      evt.in1_sig_loss = 1'b0;
      req.wr = 1'b0;
      req.rd = 1'b0;
      ce = 1'b1;
      step();
      rd_chk(8'h08, 8'h80, "ce_frozen");
      reg_write(8'h08, 8'h80);
      rd_chk(8'h08, 8'h00, "ce_after_clear");
   endtask

   task automatic t_freq;
      main_f = 19'h5a5a5;
      sec_f = 19'h2ffff;
      step();
      rd_chk(8'h07, 8'h05, "freq_main");
      sel = 1'b1;
      step();
      rd_chk(8'h07, 8'h02, "freq_second");
      evt.frame_sync_alarm = 1'b1;
      step();
      evt.frame_sync_alarm = 1'b0;
      reg_write(8'h07, 8'hff);
      reg_write(8'h3c, 8'hff);
      rd_chk(8'h07, 8'h02, "freq_ro");
      rd_chk(8'h08, 8'h80, "flags_untouched");
      reg_write(8'h08, 8'h80);
      rd_chk(8'h08, 8'h00, "flags_final");
   endtask

   // ****************************************************************
   // Main sequence and watchdog
   // ****************************************************************
   initial begin
      repeat (5) @(posedge clk_sys);
      #1;
      nrst = 1'b1;
      step();
      t_reset_clear();
      t_events();
      t_lock();
      t_phase();
      t_coincide();
      t_ce();
      t_freq();
      conclude();
   end

   initial begin
      #1000000;
      miscompares++;
      conclude();
   end
endmodule
